/* design/pafs_defines.vh */
// register map, field positions, reset values and function codes of the port a pin selector
`ifndef PAFS_DEFINES_VH
`define PAFS_DEFINES_VH

`define PAFS_OFS_HIGH       12'h000
`define PAFS_OFS_LOW_UPPER  12'h004
`define PAFS_OFS_LOW_LOWER  12'h008
`define PAFS_OFS_STATUS     12'h00C

`define PAFS_MASK_HIGH      16'h55F5
`define PAFS_MASK_LOW_UPPER 16'h555F
`define PAFS_MASK_LOW_LOWER 16'hFD75

`define PAFS_RST_HIGH       16'h0000
`define PAFS_RST_LOW_UP_EXT 16'h4000
`define PAFS_RST_LOW_UP_SC  16'h0000
`define PAFS_RST_LOW_LOWER  16'h0000

`define PAFS_POS_PIN23      14
`define PAFS_POS_PIN22      12
`define PAFS_POS_PIN21      10
`define PAFS_POS_PIN20      8
`define PAFS_POS_PIN19_HI   7
`define PAFS_POS_PIN19_LO   6
`define PAFS_POS_PIN18_HI   5
`define PAFS_POS_PIN18_LO   4
`define PAFS_POS_PIN17      2
`define PAFS_POS_PIN16      0

`define PAFS_FN_GPIO        2'b00
`define PAFS_FN_ALT1        2'b01
`define PAFS_FN_ALT2        2'b10
`define PAFS_FN_RSVD        2'b11

`define PAFS_HTRANS_NONSEQ  2'b10
`define PAFS_HTRANS_SEQ     2'b11
`define PAFS_HRESP_OKAY     1'b0

`endif

/* design/pafs_sync.v */
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module pafs_sync #(
	parameter WIDTH = 10
) (
	input  wire             sys_clk_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] stage_a;
	reg [WIDTH-1:0] stage_b;

	// first stage feeds only the second
	always @(posedge sys_clk_i) begin
		stage_a <= async_i;
		stage_b <= stage_a;
	end

	assign sync_o = stage_b;
endmodule

/* design/pafs_func_decode.v */
// decodes the high selector and the operating mode into an effective function per pin
`timescale 1ns/1ps
`include "pafs_defines.vh"
module pafs_func_decode (
	input  wire [15:0] high_pin_selector_i,
	input  wire        single_chip_i,
	input  wire        rom_disabled_i,
	output reg  [15:0] pin_fn_o
);
	// one-bit field: first alternate function or general i/o
	function [1:0] one_bit_fn;
		input sel_bit;
		begin
			one_bit_fn = sel_bit ? `PAFS_FN_ALT1 : `PAFS_FN_GPIO;
		end
	endfunction

	// two-bit field: reserved code falls back to general i/o
	function [1:0] two_bit_fn;
		input [1:0] code;
		begin
			two_bit_fn = (code == `PAFS_FN_RSVD) ? `PAFS_FN_GPIO : code;
		end
	endfunction

	always @* begin
		pin_fn_o[15:14] = one_bit_fn(high_pin_selector_i[`PAFS_POS_PIN23]);
		pin_fn_o[13:12] = one_bit_fn(high_pin_selector_i[`PAFS_POS_PIN22]);
		pin_fn_o[11:10] = one_bit_fn(high_pin_selector_i[`PAFS_POS_PIN21]);
		pin_fn_o[9:8]   = one_bit_fn(high_pin_selector_i[`PAFS_POS_PIN20]);
		pin_fn_o[7:6]   = two_bit_fn(high_pin_selector_i[`PAFS_POS_PIN19_HI:`PAFS_POS_PIN19_LO]);
		pin_fn_o[5:4]   = two_bit_fn(high_pin_selector_i[`PAFS_POS_PIN18_HI:`PAFS_POS_PIN18_LO]);
		pin_fn_o[3:2]   = one_bit_fn(high_pin_selector_i[`PAFS_POS_PIN17]);
		pin_fn_o[1:0]   = one_bit_fn(high_pin_selector_i[`PAFS_POS_PIN16]);
		// rom disabled forces the two upper write strobes
		if (rom_disabled_i) begin
			pin_fn_o[15:14] = `PAFS_FN_ALT1;
			pin_fn_o[13:12] = `PAFS_FN_ALT1;
		end
		// single chip mode keeps every pin on general i/o
		if (single_chip_i) begin
			pin_fn_o = 16'h0000;
		end
	end
endmodule

/* design/pafs_top.v */
// port a pin function selector: ahb-lite registers and pin multiplexer for pins 23..16
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pafs_defines.vh"
module pafs_top #(
	parameter ADDR_W = 12
) (
	input  wire              sys_clk_i,
	input  wire              reset_i,
	input  wire              hsel_i,
	input  wire [ADDR_W-1:0] haddr_i,
	input  wire [1:0]        htrans_i,
	input  wire              hwrite_i,
	input  wire [2:0]        hsize_i,
	input  wire [31:0]       hwdata_i,
	input  wire              hready_i,
	output reg  [31:0]       hrdata_o,
	output reg               hreadyout_o,
	output reg               hresp_o,
	input  wire              single_chip_mode_i,
	input  wire              rom_disabled_i,
	input  wire [7:0]        pin_in_i,
	output reg  [7:0]        pin_out_o,
	output reg  [7:0]        pin_oe_o,
	input  wire [7:0]        port_data_out_i,
	input  wire [7:0]        port_dir_out_i,
	output reg  [7:0]        port_data_in_o,
	input  wire              byte3_write_strobe_n_i,
	input  wire              byte2_write_strobe_n_i,
	input  wire              col_strobe_upper_upper_n_i,
	input  wire              col_strobe_upper_lower_n_i,
	input  wire              bus_grant_ack_n_i,
	input  wire              dma1_accept_out_i,
	input  wire              dma0_accept_out_i,
	input  wire              address_hold_out_n_i,
	output reg               bus_request_in_n_o,
	output reg               wait_request_n_o,
	output reg  [15:0]       low_pin_selector_upper_o,
	output reg  [15:0]       low_pin_selector_lower_o
);
	// pin index within the 8-bit groups: 0 is pin 16, 7 is pin 23
	localparam P16 = 0;
	localparam P17 = 1;
	localparam P18 = 2;
	localparam P19 = 3;
	localparam P20 = 4;
	localparam P21 = 5;
	localparam P22 = 6;
	localparam P23 = 7;

	// register slots returned by the offset decode
	localparam REG_HIGH      = 2'd0;
	localparam REG_LOW_UPPER = 2'd1;
	localparam REG_LOW_LOWER = 2'd2;
	localparam REG_OTHER     = 2'd3;

	reg  [15:0] high_pin_selector;
	reg  [15:0] low_pin_selector_upper;
	reg  [15:0] low_pin_selector_lower;
	reg  [15:0] next_high;
	reg  [15:0] next_low_upper;
	reg  [15:0] next_low_lower;

	reg              wr_pending;
	reg [ADDR_W-1:0] wr_addr;

	reg  [7:0]  next_pin_out;
	reg  [7:0]  next_pin_oe;
	reg         next_bus_request_n;
	reg         next_wait_request_n;
	reg  [31:0] next_rdata;

	wire [9:0]  sync_out;
	wire [7:0]  pin_sync;
	wire        single_chip;
	wire        rom_disabled;
	wire [15:0] pin_fn;
	wire        addr_phase;
	wire        wr_high;
	wire        wr_low_upper;
	wire        wr_low_lower;
	wire [1:0]  fn_p16;
	wire [1:0]  fn_p17;
	wire [1:0]  fn_p18;
	wire [1:0]  fn_p19;
	wire [1:0]  fn_p20;
	wire [1:0]  fn_p21;
	wire [1:0]  fn_p22;
	wire [1:0]  fn_p23;

	// pins and mode straps come from outside the clock domain
	pafs_sync #(
		.WIDTH(10)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.async_i  ({rom_disabled_i, single_chip_mode_i, pin_in_i}),
		.sync_o   (sync_out)
	);

	assign pin_sync     = sync_out[7:0];
	assign single_chip  = sync_out[8];
	assign rom_disabled = sync_out[9];

	pafs_func_decode u_decode (
		.high_pin_selector_i(high_pin_selector),
		.single_chip_i      (single_chip),
		.rom_disabled_i     (rom_disabled),
		.pin_fn_o           (pin_fn)
	);

	// decode of a register offset
	function [1:0] reg_index;
		input [ADDR_W-1:0] addr;
		begin
			if (addr == `PAFS_OFS_HIGH) begin
				reg_index = REG_HIGH;
			end else if (addr == `PAFS_OFS_LOW_UPPER) begin
				reg_index = REG_LOW_UPPER;
			end else if (addr == `PAFS_OFS_LOW_LOWER) begin
				reg_index = REG_LOW_LOWER;
			end else begin
				reg_index = REG_OTHER;
			end
		end
	endfunction

	// selected pin function of one pin
	function [1:0] fn_of;
		input [15:0] fns;
		input integer idx;
		begin
			fn_of = fns[2*idx +: 2];
		end
	endfunction

	assign addr_phase = hsel_i && hready_i &&
		((htrans_i == `PAFS_HTRANS_NONSEQ) || (htrans_i == `PAFS_HTRANS_SEQ));

	// data-phase write strobes, one per selector
	assign wr_high      = wr_pending && (reg_index(wr_addr) == REG_HIGH);
	assign wr_low_upper = wr_pending && (reg_index(wr_addr) == REG_LOW_UPPER);
	assign wr_low_lower = wr_pending && (reg_index(wr_addr) == REG_LOW_LOWER);

	// effective function of each pin after the mode overrides
	assign fn_p16 = fn_of(pin_fn, P16);
	assign fn_p17 = fn_of(pin_fn, P17);
	assign fn_p18 = fn_of(pin_fn, P18);
	assign fn_p19 = fn_of(pin_fn, P19);
	assign fn_p20 = fn_of(pin_fn, P20);
	assign fn_p21 = fn_of(pin_fn, P21);
	assign fn_p22 = fn_of(pin_fn, P22);
	assign fn_p23 = fn_of(pin_fn, P23);

	// register update, with the data-phase write applied here
	always @* begin
		next_high      = high_pin_selector;
		next_low_upper = low_pin_selector_upper;
		next_low_lower = low_pin_selector_lower;
		if (wr_high) begin
			next_high = hwdata_i[15:0] & `PAFS_MASK_HIGH;
		end
		if (wr_low_upper) begin
			next_low_upper = hwdata_i[15:0] & `PAFS_MASK_LOW_UPPER;
		end
		if (wr_low_lower) begin
			next_low_lower = hwdata_i[15:0] & `PAFS_MASK_LOW_LOWER;
		end
	end

	// read data of the three selectors follows the values that stand after any write finishing now
	always @* begin
		next_rdata = 32'h0000_0000;
		case (reg_index(haddr_i))
			REG_HIGH: begin
				next_rdata = {16'h0000, next_high};
			end
			REG_LOW_UPPER: begin
				next_rdata = {16'h0000, next_low_upper};
			end
			REG_LOW_LOWER: begin
				next_rdata = {16'h0000, next_low_lower};
			end
			default: begin
				if (haddr_i == `PAFS_OFS_STATUS) begin
					next_rdata = {14'h0, rom_disabled, single_chip, pin_fn};
				end
			end
		endcase
	end

	// reset_i is the external power-on reset; nothing else clears the selectors
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			high_pin_selector <= `PAFS_RST_HIGH;
		end else begin
			high_pin_selector <= next_high;
		end
	end

	// the upper low selector takes its power-on value from the mode strap
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			if (single_chip) begin
				low_pin_selector_upper <= `PAFS_RST_LOW_UP_SC;
			end else begin
				low_pin_selector_upper <= `PAFS_RST_LOW_UP_EXT;
			end
		end else begin
			low_pin_selector_upper <= next_low_upper;
		end
	end

	// the lower low selector clears on power-on only
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			low_pin_selector_lower <= `PAFS_RST_LOW_LOWER;
		end else begin
			low_pin_selector_lower <= next_low_lower;
		end
	end

	// bus side: zero wait states, read data loaded in the address phase
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			wr_pending  <= 1'b0;
			wr_addr     <= {ADDR_W{1'b0}};
			hrdata_o    <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o     <= `PAFS_HRESP_OKAY;
		end else begin
			wr_pending  <= addr_phase && hwrite_i;
			wr_addr     <= haddr_i;
			hreadyout_o <= 1'b1;
			hresp_o     <= `PAFS_HRESP_OKAY;
			if (addr_phase && !hwrite_i) begin
				hrdata_o <= next_rdata;
			end
		end
	end

	// pin multiplexer
	always @* begin
		next_pin_out        = port_data_out_i;
		next_pin_oe         = port_dir_out_i;
		next_bus_request_n  = 1'b1;
		next_wait_request_n = 1'b1;
		if (fn_p23 == `PAFS_FN_ALT1) begin
			next_pin_out[P23] = byte3_write_strobe_n_i;
			next_pin_oe[P23]  = 1'b1;
		end
		if (fn_p22 == `PAFS_FN_ALT1) begin
			next_pin_out[P22] = byte2_write_strobe_n_i;
			next_pin_oe[P22]  = 1'b1;
		end
		if (fn_p21 == `PAFS_FN_ALT1) begin
			next_pin_out[P21] = col_strobe_upper_upper_n_i;
			next_pin_oe[P21]  = 1'b1;
		end
		if (fn_p20 == `PAFS_FN_ALT1) begin
			next_pin_out[P20] = col_strobe_upper_lower_n_i;
			next_pin_oe[P20]  = 1'b1;
		end
		case (fn_p19)
			`PAFS_FN_ALT1: begin
				next_pin_out[P19] = bus_grant_ack_n_i;
				next_pin_oe[P19]  = 1'b1;
			end
			`PAFS_FN_ALT2: begin
				next_pin_out[P19] = dma1_accept_out_i;
				next_pin_oe[P19]  = 1'b1;
			end
			default: begin
				next_pin_out[P19] = port_data_out_i[P19];
				next_pin_oe[P19]  = port_dir_out_i[P19];
			end
		endcase
		case (fn_p18)
			`PAFS_FN_ALT1: begin
				next_pin_out[P18]  = 1'b0;
				next_pin_oe[P18]   = 1'b0;
				next_bus_request_n = pin_sync[P18];
			end
			`PAFS_FN_ALT2: begin
				next_pin_out[P18] = dma0_accept_out_i;
				next_pin_oe[P18]  = 1'b1;
			end
			default: begin
				next_pin_out[P18] = port_data_out_i[P18];
				next_pin_oe[P18]  = port_dir_out_i[P18];
			end
		endcase
		if (fn_p17 == `PAFS_FN_ALT1) begin
			next_pin_out[P17]   = 1'b0;
			next_pin_oe[P17]    = 1'b0;
			next_wait_request_n = pin_sync[P17];
		end
		if (fn_p16 == `PAFS_FN_ALT1) begin
			next_pin_out[P16] = address_hold_out_n_i;
			next_pin_oe[P16]  = 1'b1;
		end
	end

	// every pin-side output comes from a flip-flop
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			pin_out_o                <= 8'h00;
			pin_oe_o                 <= 8'h00;
			port_data_in_o           <= 8'h00;
			bus_request_in_n_o       <= 1'b1;
			wait_request_n_o         <= 1'b1;
			low_pin_selector_upper_o <= 16'h0000;
			low_pin_selector_lower_o <= 16'h0000;
		end else begin
			pin_out_o                <= next_pin_out;
			pin_oe_o                 <= next_pin_oe;
			port_data_in_o           <= pin_sync;
			bus_request_in_n_o       <= next_bus_request_n;
			wait_request_n_o         <= next_wait_request_n;
			low_pin_selector_upper_o <= low_pin_selector_upper;
			low_pin_selector_lower_o <= low_pin_selector_lower;
		end
	end
endmodule

/* verification/pafs_top_asserts.sv */
// port checks of the port a pin function selector
`timescale 1ns/1ps
`include "pafs_defines.vh"
module pafs_top_asserts #(
	parameter ADDR_W = 12
) (
	input wire              sys_clk_i,
	input wire              reset_i,
	input wire              hsel_i,
	input wire              hready_i,
	input wire              hwrite_i,
	input wire [1:0]        htrans_i,
	input wire [ADDR_W-1:0] haddr_i,
	input wire [31:0]       hwdata_i,
	input wire [31:0]       hrdata_o,
	input wire              single_chip_mode_i,
	input wire              rom_disabled_i,
	input wire [7:0]        port_dir_out_i,
	input wire [7:0]        pin_oe_o,
	input wire              bus_request_in_n_o,
	input wire              wait_request_n_o,
	input wire [15:0]       low_pin_selector_upper_o,
	input wire [15:0]       low_pin_selector_lower_o
);
	wire rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
	wire wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
	wire hi = haddr_i == `PAFS_OFS_HIGH;
	wire up = haddr_i == `PAFS_OFS_LOW_UPPER;
	wire lo = haddr_i == `PAFS_OFS_LOW_LOWER;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	property p_high_spare;
		rd && hi |=> (hrdata_o & 32'hFFFF_AA0A) == 32'h0000_0000;
	endproperty
	a_high_spare: assert property (p_high_spare) else $error("high spare bits set");
	property p_low_spare;
		rd && lo |=> (hrdata_o & 32'hFFFF_028A) == 32'h0000_0000;
	endproperty
	a_low_spare: assert property (p_low_spare) else $error("low spare bits set");
	property p_lower_write;
		wr && lo |-> ##3
			{16'h0000, low_pin_selector_lower_o} == ($past(hwdata_i, 2) & 32'h0000_FD75);
	endproperty
	a_lower_write: assert property (p_lower_write) else $error("lower copy wrong");
	property p_upper_write;
		wr && up |-> ##3
			{16'h0000, low_pin_selector_upper_o} == ($past(hwdata_i, 2) & 32'h0000_555F);
	endproperty
	a_upper_write: assert property (p_upper_write) else $error("upper copy wrong");
	property p_reset_vals;
		$fell(reset_i) |=> low_pin_selector_lower_o == 16'h0000 &&
			low_pin_selector_upper_o == (single_chip_mode_i ? 16'h0000 : 16'h4000);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");
	property p_hold;
		!(wr && lo) [*4] |=> $stable(low_pin_selector_lower_o);
	endproperty
	a_hold: assert property (p_hold) else $error("lower copy changed");
	property p_rom_force;
		(!single_chip_mode_i && rom_disabled_i) [*4] |=> pin_oe_o[7:6] == 2'b11;
	endproperty
	a_rom_force: assert property (p_rom_force) else $error("strobes not forced");
	property p_single;
		single_chip_mode_i [*4] |=> pin_oe_o == $past(port_dir_out_i) &&
			bus_request_in_n_o && wait_request_n_o;
	endproperty
	a_single: assert property (p_single) else $error("single chip not gpio");
endmodule
bind pafs_top pafs_top_asserts #(.ADDR_W(ADDR_W)) i_chk (.sys_clk_i, .reset_i, .hsel_i,
	.hready_i, .hwrite_i, .htrans_i, .haddr_i, .hwdata_i, .hrdata_o, .single_chip_mode_i,
	.rom_disabled_i, .port_dir_out_i, .pin_oe_o, .bus_request_in_n_o, .wait_request_n_o,
	.low_pin_selector_upper_o, .low_pin_selector_lower_o);

/* verification/tb_pafs_top.sv */
// testbench of the port a pin function selector
`timescale 1ns/1ps
`include "pafs_defines.vh"
module tb_pafs_top;
	localparam logic [31:0] TBL [13] = '{32'h4000_8000, 32'h1000_4000, 32'h0400_2000,
		32'h0100_1000, 32'h0040_0800, 32'h0080_0800, 32'h00C0_0000, 32'h0010_0004,
		32'h0020_0400, 32'h0030_0000, 32'h0004_0002, 32'h0001_0100, 32'h0000_0000};
	localparam logic [11:0] RA [3] = '{`PAFS_OFS_HIGH, `PAFS_OFS_LOW_UPPER, `PAFS_OFS_LOW_LOWER};
	localparam logic [31:0] RM [3] = '{32'h0000_55F5, 32'h0000_555F, 32'h0000_FD75};
	localparam logic [31:0] RV [3] = '{32'h0000_0000, 32'h0000_4000, 32'h0000_0000};
	logic        sys_clk_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
	logic        single_chip_mode_i = 1'b0, rom_disabled_i = 1'b0;
	logic [1:0]  htrans_i = 2'b00;
	logic [11:0] haddr_i = 12'h000;
	logic [31:0] hwdata_i = 32'h0000_0000;
	logic [7:0]  pin_in_i = 8'h00, port_data_out_i = 8'h00, port_dir_out_i = 8'h00, pe = 8'h00;
	wire         hreadyout_o, hresp_o, bus_request_in_n_o, wait_request_n_o;
	wire  [31:0] hrdata_o;
	wire  [7:0]  pin_out_o, pin_oe_o, port_data_in_o;
	int          bad_count = 0, n_checks = 0, cyc = 0;
	pafs_top i_dut (.sys_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
		.hresp_o, .single_chip_mode_i, .rom_disabled_i, .pin_in_i, .pin_out_o, .pin_oe_o,
		.port_data_out_i, .port_dir_out_i, .port_data_in_o, .byte3_write_strobe_n_i(pe[7]),
		.byte2_write_strobe_n_i(pe[6]), .col_strobe_upper_upper_n_i(pe[5]),
		.col_strobe_upper_lower_n_i(pe[4]), .bus_grant_ack_n_i(pe[3]),
		.dma1_accept_out_i(pe[2]), .dma0_accept_out_i(pe[1]), .address_hold_out_n_i(pe[0]),
		.bus_request_in_n_o, .wait_request_n_o, .low_pin_selector_upper_o(),
		.low_pin_selector_lower_o());
	always #2.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic stop_test;
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge sys_clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		hwrite_i <= w;
		htrans_i <= `PAFS_HTRANS_NONSEQ;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
		chk("hresp_o", 32'h0000_0000, {31'h0, hresp_o});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk("register", e, q);
	endtask
	task automatic rst;
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
	endtask
	task automatic t_regs;
		logic [31:0] q;
		for (int i = 0; i < 3; i++) begin
			rd(RA[i], RV[i]);
			bus(1'b1, RA[i], RM[i] | 32'hFFFF_0000, q);
			rd(RA[i], RM[i]);
		end
		bus(1'b1, 12'h010, 32'hFFFF_FFFF, q);
		rd(12'h010, 32'h0000_0000);
	endtask
	task automatic t_pins;
		logic [31:0] q;
		logic [15:0] hv;
		logic [7:0]  om, im, sv, pol, eo;
		for (int p = 0; p < 2; p++) begin
			pol = p ? 8'hFF : 8'h00;
			for (int i = 0; i < 13; i++) begin
				{hv, om, im} = TBL[i];
				bus(1'b1, `PAFS_OFS_HIGH, {16'h0000, hv}, q);
				pe <= 8'h55 ^ pol;
				port_data_out_i <= 8'hA5 ^ pol;
				port_dir_out_i <= 8'h3C ^ pol;
				pin_in_i <= pol;
				repeat (6) @(posedge sys_clk_i);
				sv = (8'h51 | ((hv[7:6] == 2'b10) ? 8'h08 : 8'h00)) ^ pol;
				eo = (port_dir_out_i & ~(om | im)) | om;
				chk("pin_oe_o", {24'h0, eo}, {24'h0, pin_oe_o});
				chk("pin_out_o", {24'h0, ((port_data_out_i & ~om) | (sv & om)) & eo},
					{24'h0, pin_out_o & eo});
				chk("bus_request_in_n_o", {31'h0, im[2] ? pin_in_i[2] : 1'b1},
					{31'h0, bus_request_in_n_o});
				chk("wait_request_n_o", {31'h0, im[1] ? pin_in_i[1] : 1'b1},
					{31'h0, wait_request_n_o});
				chk("port_data_in_o", {24'h0, pin_in_i}, {24'h0, port_data_in_o});
			end
		end
	endtask
	task automatic t_modes;
		logic [31:0] q;
		logic [7:0]  d;
		rom_disabled_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		chk("pin_oe_o", 32'h0000_00C0, {24'h0, pin_oe_o & 8'hC0});
		chk("pin_out_o", {24'h0, pe & 8'hC0}, {24'h0, pin_out_o & 8'hC0});
		rd(`PAFS_OFS_STATUS, 32'h0002_5000);
		bus(1'b1, `PAFS_OFS_LOW_LOWER, 32'h0000_1034, q);
		bus(1'b1, `PAFS_OFS_HIGH, 32'h0000_5595, q);
		single_chip_mode_i <= 1'b1;
		pin_in_i <= 8'h00;
		repeat (6) @(posedge sys_clk_i);
		d = port_dir_out_i;
		chk("pin_oe_o", {24'h0, d}, {24'h0, pin_oe_o});
		chk("pin_out_o", {24'h0, port_data_out_i & d}, {24'h0, pin_out_o & d});
		chk("requests", 32'h0000_0003,
			{30'h0, bus_request_in_n_o, wait_request_n_o});
		rd(`PAFS_OFS_STATUS, 32'h0003_0000);
		rst();
		for (int i = 0; i < 3; i++)
			rd(RA[i], 32'h0000_0000);
	endtask
	initial begin
		rst();
		t_regs();
		t_pins();
		t_modes();
		stop_test();
	end
endmodule
